/* File: tws_pkg.sv */
// Purpose: Shared constants and types for the three-wire serial port.
// Assumes: 8-bit register port, peripheral clock equals the block clock.
// Notes:   Offsets are byte addresses on the 16-bit register address.
package tws_pkg;

    // Register addresses.
    localparam logic [15:0] MODE_ADDR   = 16'hff80;
    localparam logic [15:0] CLKSEL_ADDR = 16'hff81;
    localparam logic [15:0] TXBUF_ADDR  = 16'hff82;
    localparam logic [15:0] SHREG_ADDR  = 16'hff83;

    // Reset values.
    localparam logic [7:0] MODE_RESET   = 8'h00;
    localparam logic [7:0] CLKSEL_RESET = 8'h00;
    localparam logic [7:0] TXBUF_RESET  = 8'h00;
    localparam logic [7:0] SHREG_RESET  = 8'h00;

    // Mode register field positions.
    localparam int MODE_EN_BIT   = 7;
    localparam int MODE_TRMD_BIT = 6;
    localparam int MODE_DIR_BIT  = 4;
    localparam int MODE_BUSY_BIT = 0;

    // Clock select register field positions.
    localparam int CLK_POL_BIT   = 4;
    localparam int CLK_PHASE_BIT = 3;
    localparam int CLK_SEL_MSB   = 2;
    localparam int CLK_SEL_LSB   = 0;

    // Clock select code that hands the clock pin to the partner.
    localparam logic [2:0] CLK_SEL_EXT = 3'h7;

    // Transfer geometry and buffering.
    localparam int          DATA_BITS  = 8;
    localparam logic [3:0]  LAST_BIT   = 4'h7;
    localparam logic [3:0]  ALL_BITS   = 4'h8;
    localparam int          FIFO_DEPTH = 4;
    localparam int          DIV_W      = 7;
    localparam logic [6:0]  DIV_ONE    = 7'h01;

    // Software view of the mode register.
    typedef struct packed {
        logic enable;
        logic txRxMode;
        logic lsbFirst;
    } tws_mode_t;

    // Software view of the clock select register.
    typedef struct packed {
        logic       polarity;
        logic       phase;
        logic [2:0] clkSel;
    } tws_clksel_t;

    // One register access from the processor side.
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
        logic        write;
        logic        read;
    } tws_access_t;

endpackage : tws_pkg

/* File: tws_fifo.sv */
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: Single clock; flush empties the FIFO in one cycle.
// Notes:   Output data is read straight from the array while valid.
module tws_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             flush,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0]    wrPtr_ff;
    logic [PW-1:0]    rdPtr_ff;
    logic [CW-1:0]    count_ff;
    wire              doPush = inValid & inReady;
    wire              doPop  = outValid & outReady;

    // Ready and valid follow the occupancy count, and both are held low during a flush.
    assign inReady  = (count_ff != FULL_CNT) & ~flush;
    assign outValid = (count_ff != '0) & ~flush;
    assign outData  = mem_ff[rdPtr_ff];

    // Storage array is written without reset; only pointers and the count need one.
    always_ff @(posedge clock) begin
        if (doPush) begin
            mem_ff[wrPtr_ff] <= inData;
        end
    end

    // Pointers wrap at the depth, so a non power-of-two depth also works.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end else if (flush) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (doPush) begin
                wrPtr_ff <= (wrPtr_ff == LAST_PTR) ? '0 : wrPtr_ff + PW'(1);
            end
            if (doPop) begin
                rdPtr_ff <= (rdPtr_ff == LAST_PTR) ? '0 : rdPtr_ff + PW'(1);
            end
            count_ff <= count_ff + CW'(doPush) - CW'(doPop);
        end
    end

endmodule : tws_fifo

/* File: tws_three_wire_port.sv */
// Purpose: Three-wire clocked serial port, master or slave, 8-bit units.
// Assumes: Pins and register strobes are synchronous to clock.
// Notes:   Transmit buffer writes queue in a 4-word FIFO ahead of the shifter.
module tws_three_wire_port
    import tws_pkg::*;
#(
    parameter int BUF_DEPTH = FIFO_DEPTH
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [15:0] busAddr,
    input  wire logic        busWrite,
    input  wire logic        busRead,
    input  wire logic [7:0]  busWdata,
    output logic [7:0]       busRdata,
    output logic             txReady,
    input  wire logic        sckIn,
    output logic             sckOut,
    output logic             sckOeN,
    input  wire logic        siIn,
    output logic             soOut,
    output logic             soOeN,
    output logic             transferDone
);

    // Register state.
    tws_mode_t   mode_ff;
    tws_clksel_t clkSel_ff;
    logic [7:0]  txBuf_ff;
    logic [7:0]  shReg_ff;
    logic [7:0]  rdData_ff;

    // Transfer engine state.
    logic        busy_ff;
    logic [3:0]  bitCnt_ff;
    logic        soLat_ff;
    logic        sckGen_ff;
    logic        sckPrev_ff;
    logic [DIV_W-1:0] divCnt_ff;
    logic        done_ff;

    // Bus request gathered into one carrier.
    tws_access_t acc;
    assign acc = '{addr: busAddr, data: busWdata, write: busWrite, read: busRead};

    // Address decoding.
    wire selMode   = (acc.addr == MODE_ADDR);
    wire selClkSel = (acc.addr == CLKSEL_ADDR);
    wire selTxBuf  = (acc.addr == TXBUF_ADDR);
    wire selShReg  = (acc.addr == SHREG_ADDR);
    wire wrMode    = acc.write & selMode;
    wire wrClkSel  = acc.write & selClkSel;
    wire wrTxBuf   = acc.write & selTxBuf;
    wire rdShReg   = acc.read & selShReg;

    // Decoded configuration.
    wire        enabled  = mode_ff.enable;
    wire        txMode   = mode_ff.txRxMode;
    wire        lsbFirst = mode_ff.lsbFirst;
    wire        phase1   = clkSel_ff.phase;
    wire        sckIdle  = ~clkSel_ff.polarity;
    wire        isSlave  = (clkSel_ff.clkSel == CLK_SEL_EXT);

    // Transmit FIFO in front of the shifter.
    logic       fifoOutValid;
    logic [7:0] fifoOutData;
    wire        fifoPush = wrTxBuf & enabled & txMode;
    wire        canStart = enabled & ~busy_ff;
    wire        fifoPop  = canStart & txMode;

    wire startXfer = txMode ? (canStart & fifoOutValid) : (canStart & rdShReg);

    // Queued words count as communication in progress, so busy covers them.
    wire statusBusy = busy_ff | (fifoOutValid & txMode);

    tws_fifo #(
        .WIDTH (DATA_BITS),
        .DEPTH (BUF_DEPTH)
    ) u_txfifo (
        .clock    (clock),
        .rst      (rst),
        .flush    (~enabled),
        .inValid  (fifoPush),
        .inReady  (txReady),
        .inData   (acc.data),
        .outValid (fifoOutValid),
        .outReady (fifoPop),
        .outData  (fifoOutData)
    );

    // divide by 2 to 128
    // The half period is 2^code cycles, so code 0 gives a clock/2 serial clock.
    wire [DIV_W-1:0] halfMax = (DIV_ONE << clkSel_ff.clkSel) - DIV_ONE;
    wire             divTick = busy_ff & ~isSlave & (divCnt_ff == halfMax);

    // Edge events, leading leaves the idle level and trailing returns to it.
    wire mLead  = divTick & (sckGen_ff == sckIdle);
    wire mTrail = divTick & (sckGen_ff != sckIdle);
    wire sLead  = busy_ff & isSlave & (sckIn != sckIdle) & (sckPrev_ff == sckIdle);
    wire sTrail = busy_ff & isSlave & (sckIn == sckIdle) & (sckPrev_ff != sckIdle);
    wire leadEv  = isSlave ? sLead : mLead;
    wire trailEv = isSlave ? sTrail : mTrail;

    // Phase 0 samples on trailing edges, phase 1 on leading edges.
    wire sampleEv = phase1 ? leadEv : trailEv;
    wire outEv    = phase1 ? trailEv : leadEv;

    // eight bits then stop
    // Phase 1 still owes the closing trailing edge after its eighth sample.
    wire lastEv = phase1 ? (trailEv & (bitCnt_ff == ALL_BITS))
                         : (sampleEv & (bitCnt_ff == LAST_BIT));

    wire outBitSh   = lsbFirst ? shReg_ff[0] : shReg_ff[7];
    wire outBitFifo = lsbFirst ? fifoOutData[0] : fifoOutData[7];
    wire outBitBuf  = lsbFirst ? txBuf_ff[0] : txBuf_ff[7];
    wire [7:0] shiftedIn = lsbFirst ? {siIn, shReg_ff[7:1]} : {shReg_ff[6:0], siIn};

    wire outUpdate = outEv & txMode & ~(phase1 & (bitCnt_ff == ALL_BITS));

    // Next values of the shift register and output latch.
    wire [7:0] nxt_shReg = (startXfer & txMode) ? fifoOutData :
                           sampleEv             ? shiftedIn   : shReg_ff;
    wire nxt_soLat = (startXfer & txMode & phase1) ? outBitFifo :
                     outUpdate                     ? outBitSh   : soLat_ff;

    // disable clears logic
    // Clearing one cycle after the write avoids a reset driven by a register,
    // at the cost of the clear not being truly asynchronous.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_ff   <= tws_mode_t'(3'h0);
            clkSel_ff <= tws_clksel_t'(CLKSEL_RESET[4:0]);
            txBuf_ff  <= TXBUF_RESET;
        end else begin
            if (wrMode) begin
                mode_ff <= '{enable:   acc.data[MODE_EN_BIT],
                             txRxMode: acc.data[MODE_TRMD_BIT],
                             lsbFirst: acc.data[MODE_DIR_BIT]};
            end
            if (wrClkSel) begin
                clkSel_ff <= tws_clksel_t'(acc.data[CLK_POL_BIT:CLK_SEL_LSB]);
            end
            if (fifoPush & txReady) begin
                txBuf_ff <= acc.data;
            end
        end
    end

    // Read data is captured on the read strobe and shown the next cycle.
    wire [7:0] modeRead = {mode_ff.enable, mode_ff.txRxMode, 1'b0, mode_ff.lsbFirst,
                           3'h0, statusBusy};
    wire [7:0] rdMux = selMode   ? modeRead :
                       selClkSel ? {3'h0, clkSel_ff} :
                       selTxBuf  ? txBuf_ff :
                       selShReg  ? shReg_ff : 8'h00;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdData_ff <= 8'h00;
        end else if (acc.read) begin
            rdData_ff <= rdMux;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busy_ff   <= 1'b0;
            bitCnt_ff <= 4'h0;
            done_ff   <= 1'b0;
        end else if (!enabled) begin
            busy_ff   <= 1'b0;
            bitCnt_ff <= 4'h0;
            done_ff   <= 1'b0;
        end else begin
            done_ff <= lastEv;
            if (startXfer) begin
                busy_ff   <= 1'b1;
                bitCnt_ff <= 4'h0;
            end else if (lastEv) begin
                busy_ff <= 1'b0;
            end else if (sampleEv) begin
                bitCnt_ff <= bitCnt_ff + 4'h1;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            shReg_ff <= SHREG_RESET;
            soLat_ff <= 1'b0;
        end else if (!enabled) begin
            shReg_ff <= SHREG_RESET;
            soLat_ff <= 1'b0;
        end else begin
            shReg_ff <= nxt_shReg;
            soLat_ff <= nxt_soLat;
        end
    end

    // Master clock generator; it rests at the idle level between transfers.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sckGen_ff <= 1'b1;
            divCnt_ff <= '0;
        end else if (!busy_ff || isSlave) begin
            sckGen_ff <= sckIdle;
            divCnt_ff <= '0;
        end else if (divTick) begin
            sckGen_ff <= ~sckGen_ff;
            divCnt_ff <= '0;
        end else begin
            divCnt_ff <= divCnt_ff + DIV_ONE;
        end
    end

    // Previous external clock level for slave edge detection.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sckPrev_ff <= 1'b1;
        end else begin
            sckPrev_ff <= sckIn;
        end
    end

    // release unused pins
    // Enables are active low; the clock pin is driven only as enabled master.
    assign sckOeN = ~(enabled & ~isSlave);
    assign soOeN  = ~(enabled & txMode);
    assign sckOut = sckGen_ff;

    // receive mode low
    // With the port off in phase 1 the line previews the first buffer bit.
    assign soOut = !txMode              ? 1'b0 :
                   (!enabled && phase1) ? outBitBuf : soLat_ff;

    assign busRdata     = rdData_ff;
    assign transferDone = done_ff;

endmodule : tws_three_wire_port

/* File: tws_partner.sv */
// Purpose: Behavioural peripheral on the far side of the three-wire port.
// Assumes: Pin values are synchronous to clock.
// Notes:   It drives the clock only when told to act as clock source.
module tws_partner
    import tws_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       pol,
    input  wire logic       phase,
    input  wire logic       lsbFirst,
    input  wire logic       sckPin,
    input  wire logic       soPin,
    input  wire logic [7:0] txByte,
    input  wire logic       slaveGo,
    output logic            siOut,
    output logic            sckDrv,
    output logic [7:0]      rxByte
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       prevFf;
    logic [2:0] idxFf;
    logic [5:0] genFf;
    wire        edgeNow = sckPin != prevFf;
    wire        lead    = edgeNow && (prevFf == ~pol);

    // eight bits a frame; phase picks which edge samples.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prevFf <= ~pol;
            idxFf  <= 3'h0;
            siOut  <= 1'b0;
            rxByte <= 8'h00;
        end else begin
            prevFf <= sckPin;
            if (edgeNow && (lead ^ phase)) siOut <= txByte[lsbFirst ? idxFf : 3'h7 - idxFf];
            // Phase 1 samples on the first edge, so the first bit must wait on the line.
            if (!edgeNow && phase && idxFf == 3'h0) siOut <= txByte[lsbFirst ? 3'h0 : 3'h7];
            if (edgeNow && (lead ~^ phase)) begin
                rxByte <= lsbFirst ? {soPin, rxByte[7:1]} : {rxByte[6:0], soPin};
                idxFf  <= idxFf + 3'h1;
                // A released line shows the inverse so a stale bit never passes.
                if (idxFf == 3'h7) siOut <= ~siOut;
            end
        end
    end

    // clock source in slave operation: 16 half periods of 4 cycles.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            genFf  <= 6'h00;
            sckDrv <= ~pol;
        end else if (slaveGo || genFf != 6'h00) begin
            genFf <= genFf + 6'h01;
            if (genFf[1:0] == 2'h3) sckDrv <= ~sckDrv;
        end
    end
endmodule : tws_partner

/* File: tws_chk.sv */
// Purpose: Concurrent checks on the ports of the three-wire port.
// Assumes: Settings change only while the port is disabled.
// Notes:   Settings are mirrored from the register writes it sees.
module tws_chk
    import tws_pkg::*;
#(
    parameter int BUF_DEPTH = FIFO_DEPTH
) (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic [15:0] busAddr,
    input wire logic        busWrite,
    input wire logic        busRead,
    input wire logic [7:0]  busWdata,
    input wire logic [7:0]  busRdata,
    input wire logic        txReady,
    input wire logic        sckIn,
    input wire logic        sckOut,
    input wire logic        sckOeN,
    input wire logic        siIn,
    input wire logic        soOut,
    input wire logic        soOeN,
    input wire logic        transferDone
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       enFf;
    logic       trmdFf;
    logic [2:0] codeFf;
    logic       pinFf;
    logic [4:0] edgeFf;
    logic [7:0] gapFf;
    wire        pin     = sckOeN ? sckIn : sckOut;
    wire        pinEdge = pin != pinFf;

    // Settings mirror, serial edges per frame and cycles between edges.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            enFf   <= 1'b0;
            trmdFf <= 1'b0;
            codeFf <= 3'h0;
            pinFf  <= 1'b1;
            edgeFf <= 5'h00;
            gapFf  <= 8'h00;
        end else begin
            if (busWrite && busAddr == MODE_ADDR) enFf <= busWdata[MODE_EN_BIT];
            if (busWrite && busAddr == MODE_ADDR) trmdFf <= busWdata[MODE_TRMD_BIT];
            if (busWrite && busAddr == CLKSEL_ADDR) codeFf <= busWdata[2:0];
            pinFf  <= pin;
            // The count restarts after each done pulse, so a queued frame begins at zero.
            edgeFf <= (enFf && !transferDone) ? edgeFf + {4'h0, pinEdge} : 5'h00;
            gapFf  <= pinEdge ? 8'h01 : gapFf + {7'h00, gapFf != 8'hff};
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_off_released:
        assert property (!enFf && !$past(enFf) |-> sckOeN && soOeN) else $error("pin driven off");
    a_rx_so_low:
        assert property (!trmdFf && !$past(trmdFf) |-> !soOut && soOeN) else $error("data out set");
    a_tx_so_driven:
        assert property (enFf && $past(enFf) && trmdFf && $past(trmdFf) |-> !soOeN)
            else $error("data out released");
    a_slave_clk_in:
        assert property (enFf && codeFf == CLK_SEL_EXT |-> sckOeN) else $error("slave drives clock");
    a_master_clk_out:
        assert property (enFf && $past(enFf) && codeFf != CLK_SEL_EXT |-> !sckOeN)
            else $error("master clock released");
    a_done_single:
        assert property (transferDone |=> !transferDone) else $error("done too long");
    a_eight_bits:
        assert property (transferDone |-> edgeFf + {4'h0, pinEdge} == 5'h10)
            else $error("wrong edge count");
    a_clock_rate:
        assert property (pinEdge && !sckOeN && edgeFf != 5'h00 |-> gapFf == (8'h01 << codeFf))
            else $error("wrong half period");
    a_last_held:
        assert property (transferDone && trmdFf |-> $stable(soOut)) else $error("last bit lost");
    a_mode_zeros:
        assert property (busRead && busAddr == MODE_ADDR |=> busRdata[5] == 1'b0
            && busRdata[3:1] == 3'h0) else $error("reserved bit set");
    c_slave: cover property (transferDone && codeFf == CLK_SEL_EXT);
    c_rx_only: cover property (transferDone && !trmdFf);
    c_queue_full: cover property (enFf && !txReady);
endmodule : tws_chk

bind tws_three_wire_port tws_chk #(.BUF_DEPTH(BUF_DEPTH)) u_tws_chk (
    .clock(clock), .rst(rst), .busAddr(busAddr), .busWrite(busWrite), .busRead(busRead),
    .busWdata(busWdata), .busRdata(busRdata), .txReady(txReady), .sckIn(sckIn),
    .sckOut(sckOut), .sckOeN(sckOeN), .siIn(siIn), .soOut(soOut), .soOeN(soOeN),
    .transferDone(transferDone));

/* File: tb_top.sv */
// Purpose: Self-checking bench for the three-wire serial port.
// Assumes: The partner model answers on the serial pins.
// Notes:   Register accesses leave an idle cycle between strobes.
module tb_top
    import tws_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clock, rst, busWrite, busRead, siIn, pRst, slaveGo, pol, phase, lsb;
    logic [15:0] busAddr;
    logic [7:0]  busWdata, busRdata, rxByte, pTx, dat;
    logic        txReady, sckOut, sckOeN, soOut, soOeN, transferDone, sckDrv;
    int          n_errors, check_count;
    wire         sckPin = sckOeN ? sckDrv : sckOut;

    tws_three_wire_port u_tws_three_wire_port (
        .clock(clock), .rst(rst), .busAddr(busAddr), .busWrite(busWrite), .busRead(busRead),
        .busWdata(busWdata), .busRdata(busRdata), .txReady(txReady), .sckIn(sckPin),
        .sckOut(sckOut), .sckOeN(sckOeN), .siIn(siIn), .soOut(soOut), .soOeN(soOeN),
        .transferDone(transferDone));
    tws_partner u_tws_partner (
        .clock(clock), .rst(rst | pRst), .pol(pol), .phase(phase), .lsbFirst(lsb),
        .sckPin(sckPin), .soPin(soOut), .txByte(pTx), .slaveGo(slaveGo), .siOut(siIn),
        .sckDrv(sckDrv), .rxByte(rxByte));

    // Free-running 250 MHz clock.
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic report_and_stop();
        if (n_errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    // Bus tasks start just after an edge and end just after an edge.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        busAddr  = a;
        busWdata = d;
        busWrite = 1'b1;
        @(posedge clock) #1 busWrite = 1'b0;
        @(posedge clock) #1;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        busAddr = a;
        busRead = 1'b1;
        @(posedge clock) #1 busRead = 1'b0;
        chk(busRdata, exp);
        @(posedge clock) #1;
    endtask : rd

    task automatic waitDone();
        for (int i = 0; i < 3000 && transferDone !== 1'b1; i++) @(posedge clock) #1;
        chk(8'(transferDone), 8'h01);
        @(posedge clock) #1;
    endtask : waitDone

    // disable, clock settings, mode, then enable; the partner restarts too.
    task automatic setup(input logic p, input logic f, input logic [2:0] c,
                         input logic m, input logic l);
        wr(MODE_ADDR, 8'h00);
        pol   = p;
        phase = f;
        lsb   = l;
        pRst  = 1'b1;
        wr(CLKSEL_ADDR, {3'h0, p, f, c});
        pRst  = 1'b0;
        wr(MODE_ADDR, {1'b0, m, 1'b0, l, 4'h0});
        wr(MODE_ADDR, {1'b1, m, 1'b0, l, 4'h0});
    endtask : setup

    // Watchdog: the run needs about 1500 cycles.
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        report_and_stop();
    end

    // Main sequence.
    initial begin
        {rst, busWrite, busRead, pRst, slaveGo, pol, phase, lsb} = 8'h80;
        {busAddr, busWdata, pTx} = 32'h0000_0000;
        n_errors    = 0;
        check_count = 0;
        repeat (10) @(posedge clock);
        #1 rst = 1'b0;
        @(posedge clock) #1;
        rd(MODE_ADDR, MODE_RESET);
        rd(CLKSEL_ADDR, CLKSEL_RESET);
        rd(SHREG_ADDR, SHREG_RESET);
        rd(16'hff90, 8'h00);
        chk(8'({sckOeN, soOeN}), 8'h03);
        for (int t = 0; t < 4; t++) begin
            dat = 8'h96 ^ 8'(t);
            pTx = 8'h3c + 8'(t);
            setup(t[1], t[0], 3'h1, 1'b1, t[1] ^ t[0]);
            wr(TXBUF_ADDR, dat);
            @(posedge clock) #1;
            if (t[0]) chk(8'(soOut), 8'(lsb ? dat[0] : dat[7]));
            waitDone();
            chk(rxByte, dat);
            chk(8'(soOut), 8'(lsb ? dat[7] : dat[0]));
            rd(MODE_ADDR, {2'h3, 1'b0, lsb, 4'h0});
            rd(SHREG_ADDR, pTx);
        end
        // Fill the queue until it refuses, then let it drain in order.
        setup(1'b0, 1'b0, 3'h0, 1'b1, 1'b0);
        for (int i = 0; i < 5; i++) begin
            chk(8'(txReady), 8'h01);
            wr(TXBUF_ADDR, 8'h10 + 8'(i));
        end
        chk(8'(txReady), 8'h00);
        wr(TXBUF_ADDR, 8'hee);
        repeat (5) waitDone();
        chk(rxByte, 8'h14);
        rd(TXBUF_ADDR, 8'h14);
        // Receive only at the slowest master rate, then abort a second one.
        setup(1'b0, 1'b0, 3'h6, 1'b0, 1'b1);
        pTx = 8'hc3;
        rd(SHREG_ADDR, 8'h00);
        chk(8'({soOut, soOeN}), 8'h01);
        waitDone();
        rd(SHREG_ADDR, 8'hc3);
        repeat (100) @(posedge clock) #1;
        wr(MODE_ADDR, 8'h40);
        rd(MODE_ADDR, 8'h40);
        rd(SHREG_ADDR, 8'h00);
        // Slave transfer, type 3, clock from the partner.
        setup(1'b1, 1'b0, CLK_SEL_EXT, 1'b1, 1'b0);
        chk(8'(sckOeN), 8'h01);
        pTx = 8'he1;
        wr(TXBUF_ADDR, 8'h2b);
        slaveGo = 1'b1;
        @(posedge clock) #1 slaveGo = 1'b0;
        waitDone();
        chk(rxByte, 8'h2b);
        rd(SHREG_ADDR, 8'he1);
        report_and_stop();
    end
endmodule : tb_top
